// >>> src/adcc_pkg.sv
/*
 * Shared constants and types of the converter control and result block:
 * register offsets, field positions, reset values, clock select codes,
 * divider ratios, trigger codes and the sequencer states.
 * Assumes an 8-bit register port with a 3-bit word address.
 */
package adcc_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int NUM_TRIG = 18;

    localparam logic [2:0] OFF_CTRL0 = 3'h0;
    localparam logic [2:0] OFF_CTRL1 = 3'h1;
    localparam logic [2:0] OFF_TRIG = 3'h2;
    localparam logic [2:0] OFF_RESH = 3'h3;
    localparam logic [2:0] OFF_RESL = 3'h4;
    localparam logic [2:0] OFF_ISTAT = 3'h5;
    localparam logic [2:0] OFF_IMASK = 3'h6;

    localparam int CTRL0_PWR_BIT = 0;
    localparam int CTRL0_RUN_BIT = 1;
    localparam int CTRL0_CHAN_LSB = 2;
    localparam int CTRL1_REF_LSB = 0;
    localparam int CTRL1_CLK_LSB = 4;
    localparam int CTRL1_JUST_BIT = 7;
    localparam int ISTAT_DONE_BIT = 0;

    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [4:0] TRIG_RST = 5'h00;
    localparam logic [7:0] RES_RST = 8'h00;
    localparam logic IMASK_RST = 1'b0;

    localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
    localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
    localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
    localparam logic [2:0] CLKSEL_RC_A = 3'h3;
    localparam logic [2:0] CLKSEL_DIV4 = 3'h4;
    localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
    localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
    localparam logic [2:0] CLKSEL_RC_B = 3'h7;

    // divider terminal counts, ratio minus one
    localparam logic [5:0] DIV2_TC = 6'h01;
    localparam logic [5:0] DIV4_TC = 6'h03;
    localparam logic [5:0] DIV8_TC = 6'h07;
    localparam logic [5:0] DIV16_TC = 6'h0f;
    localparam logic [5:0] DIV32_TC = 6'h1f;
    localparam logic [5:0] DIV64_TC = 6'h3f;

    localparam logic [1:0] VREF_SUPPLY = 2'h0;
    localparam logic [1:0] VREF_RESERVED = 2'h1;
    localparam logic [1:0] VREF_PIN = 2'h2;
    localparam logic [1:0] VREF_FIXED = 2'h3;

    localparam logic [4:0] TRIG_NONE = 5'h00;
    localparam logic [4:0] TRIG_PIN = 5'h01;
    localparam logic [4:0] TRIG_LAST = 5'h12;

    // conversion clock periods per conversion
    localparam logic [3:0] CONV_TADS = 4'hb;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_RUN = 2'b10
    } adcc_cv_e;
endpackage : adcc_pkg

// >>> src/adcc_conv_if.sv
/*
 * Link between the register side and the conversion sequencer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface adcc_conv_if;
    logic start;
    logic abort;
    logic [2:0] clk_sel;
    logic rc_tick;
    logic busy;
    logic done;

    modport ctl (output start, output abort, output clk_sel, output rc_tick,
                 input busy, input done);
    modport seq (input start, input abort, input clk_sel, input rc_tick,
                 output busy, output done);
endinterface : adcc_conv_if

// >>> src/adcc_conv.sv
/*
 * Conversion sequencer: derives the conversion clock from the system clock
 * or from the synchronised RC clock ticks, counts the conversion periods and
 * pulses done at the end.
 * Assumes start and abort are one-cycle pulses from the register side.
 */
`timescale 1ns/10ps
module adcc_conv (
    input wire logic clk_i,
    input wire logic reset_i,
    adcc_conv_if.seq cif
);
    import adcc_pkg::*;

    typedef struct packed {
        adcc_cv_e st;
        logic [5:0] div;
        logic [3:0] tads;
        logic done;
    } adcc_conv_s;

    adcc_conv_s q;
    adcc_conv_s n;
    logic [5:0] tc;
    logic rc_mode;
    logic tick;

    always_comb begin
        rc_mode = 1'b0;
        unique case (cif.clk_sel)
            CLKSEL_DIV2: tc = DIV2_TC;
            CLKSEL_DIV8: tc = DIV8_TC;
            CLKSEL_DIV32: tc = DIV32_TC;
            CLKSEL_DIV4: tc = DIV4_TC;
            CLKSEL_DIV16: tc = DIV16_TC;
            CLKSEL_DIV64: tc = DIV64_TC;
            default: begin
                tc = DIV64_TC;
                rc_mode = 1'b1;
            end
        endcase
        tick = rc_mode ? cif.rc_tick : (q.div == tc);
    end

    always_comb begin
        n = q;
        n.done = 1'b0;
        unique case (q.st)
            CV_IDLE: begin
                n.div = 6'h00;
                n.tads = 4'h0;
                if (cif.start) begin
                    n.st = CV_RUN;
                end
            end
            CV_RUN: begin
                if (cif.abort) begin
                    // clear the counters so the divider phase restarts clean
                    n.st = CV_IDLE;
                    n.div = 6'h00;
                    n.tads = 4'h0;
                end else if (tick) begin
                    n.div = 6'h00;
                    n.tads = q.tads + 4'h1;
                    if (q.tads == CONV_TADS - 4'h1) begin
                        n.done = 1'b1;
                        n.st = CV_IDLE;
                    end
                end else if (!rc_mode) begin
                    n.div = q.div + 6'h01;
                end
            end
            default: n.st = CV_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q.st <= CV_IDLE;
            q.div <= 6'h00;
            q.tads <= 4'h0;
            q.done <= 1'b0;
        end else begin
            q <= n;
        end
    end

    assign cif.busy = (q.st == CV_RUN);
    assign cif.done = q.done;

    fast_div_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (q.st == CV_RUN && cif.clk_sel == CLKSEL_DIV2 && q.div == 6'h00 && !cif.abort)
        |=> (q.div == 6'h01 || q.st == CV_IDLE) ##1 (q.div == 6'h00))
        else $error("divide by two period wrong");

    last_tad_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (q.st == CV_RUN && tick && q.tads == CONV_TADS - 4'h1 && !cif.abort)
        |=> cif.done && !cif.busy)
        else $error("done missing after last period");
endmodule : adcc_conv

// >>> src/adcc_top.sv
/*
 * Converter control and result block: register port, run flag, power,
 * clock, reference and trigger selection, auto-trigger edge detection,
 * result justification and the done interrupt.
 * Assumes trigger sources other than the pin come from logic on clk_i,
 * and the converter core holds its result stable when done is signalled.
 */
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module adcc_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [adcc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [adcc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [adcc_pkg::DATA_W-1:0] rdata_o,
    output logic irq_o,
    input wire logic [adcc_pkg::NUM_TRIG:1] trig_src_i,
    input wire logic sleep_i,
    input wire logic ext_clk_sel_i,
    input wire logic rc_clk_i,
    input wire logic [adcc_pkg::RES_W-1:0] core_result_i,
    output logic core_power_o,
    output logic core_start_o,
    output logic [5:0] chan_sel_o,
    output logic [1:0] vref_sel_o,
    output logic osc_pins_analog_off_o
);
    import adcc_pkg::*;

    typedef struct packed {
        logic pwr;
        logic [5:0] chan;
        logic run;
        logic just;
        logic [2:0] clksel;
        logic [1:0] vref;
        logic [4:0] trig;
        logic [7:0] resh;
        logic [7:0] resl;
        logic stat;
        logic mask;
        logic irq;
        logic [7:0] rdata;
        logic [NUM_TRIG:1] src_prev;
        logic [2:0] pin_sync;
        logic pin_lvl;
        logic [2:0] rc_sync;
        logic rc_lvl;
        logic rc_tick;
        logic start;
        logic abort;
        logic osc_off;
    } adcc_top_s;

    adcc_top_s q;
    adcc_top_s n;
    adcc_conv_if cif ();

    logic [NUM_TRIG:1] src_now;
    logic [NUM_TRIG:1] src_rise;
    logic trig_hit;
    logic sw_start;
    logic sw_stop;
    logic wr_ctrl0;

    adcc_conv u_conv (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .cif(cif)
    );

    assign cif.start = q.start;
    assign cif.abort = q.abort;
    assign cif.clk_sel = q.clksel;
    assign cif.rc_tick = q.rc_tick;

    always_comb begin
        n = q;
        // pin source and RC clock come from outside the clock domain
        n.pin_sync = {q.pin_sync[1:0], trig_src_i[TRIG_PIN]};
        if (q.pin_sync[1] == q.pin_sync[2]) begin
            n.pin_lvl = q.pin_sync[2];
        end
        n.rc_sync = {q.rc_sync[1:0], rc_clk_i};
        if (q.rc_sync[1] == q.rc_sync[2]) begin
            n.rc_lvl = q.rc_sync[2];
        end
        n.rc_tick = n.rc_lvl & ~q.rc_lvl;

        // edges on every source, so a change of selection makes no false edge
        src_now = trig_src_i;
        src_now[TRIG_PIN] = q.pin_lvl;
        n.src_prev = src_now;
        src_rise = src_now & ~q.src_prev;
        trig_hit = 1'b0;
        if (q.trig != TRIG_NONE && q.trig <= TRIG_LAST) begin
            trig_hit = src_rise[q.trig];
        end
        trig_hit = trig_hit & ~sleep_i;

        wr_ctrl0 = wr_i && addr_i == OFF_CTRL0;
        sw_start = wr_ctrl0 && wdata_i[CTRL0_RUN_BIT];
        sw_stop = wr_ctrl0 && !wdata_i[CTRL0_RUN_BIT];

        if (wr_i) begin
            unique case (addr_i)
                OFF_CTRL0: begin
                    n.pwr = wdata_i[CTRL0_PWR_BIT];
                    n.chan = wdata_i[CTRL0_CHAN_LSB +: 6];
                end
                OFF_CTRL1: begin
                    n.just = wdata_i[CTRL1_JUST_BIT];
                    n.clksel = wdata_i[CTRL1_CLK_LSB +: 3];
                    n.vref = wdata_i[CTRL1_REF_LSB +: 2];
                end
                OFF_TRIG: n.trig = wdata_i[4:0];
                OFF_RESH: n.resh = wdata_i;
                OFF_RESL: n.resl = wdata_i;
                OFF_IMASK: n.mask = wdata_i[ISTAT_DONE_BIT];
                default: begin
                end
            endcase
        end

        // a start while a conversion runs is ignored, not restarted
        n.start = (sw_start || trig_hit) && n.pwr && !q.run;
        n.abort = q.run && !cif.done && (sw_stop || !n.pwr);
        if (n.start) begin
            n.run = 1'b1;
        end else if (cif.done || n.abort) begin
            n.run = 1'b0;
        end

        if (cif.done) begin
            if (q.just) begin
                n.resh = {6'h00, core_result_i[9:8]};
                n.resl = core_result_i[7:0];
            end else begin
                n.resh = core_result_i[9:2];
                n.resl = {core_result_i[1:0], 6'h00};
            end
        end

        // set wins over a clear in the same cycle
        n.stat = q.stat;
        if (wr_i && addr_i == OFF_ISTAT && wdata_i[ISTAT_DONE_BIT]) begin
            n.stat = 1'b0;
        end
        if (cif.done) begin
            n.stat = 1'b1;
        end
        n.irq = n.stat & n.mask;
        n.osc_off = ext_clk_sel_i;

        n.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                OFF_CTRL0: n.rdata = {q.chan, q.run, q.pwr};
                OFF_CTRL1: n.rdata = {q.just, q.clksel, 2'h0, q.vref};
                OFF_TRIG: n.rdata = {3'h0, q.trig};
                OFF_RESH: n.rdata = q.resh;
                OFF_RESL: n.rdata = q.resl;
                OFF_ISTAT: n.rdata = {7'h00, q.stat};
                OFF_IMASK: n.rdata = {7'h00, q.mask};
                default: n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.pwr <= CTRL0_RST[CTRL0_PWR_BIT];
            q.chan <= CTRL0_RST[CTRL0_CHAN_LSB +: 6];
            q.run <= CTRL0_RST[CTRL0_RUN_BIT];
            q.just <= CTRL1_RST[CTRL1_JUST_BIT];
            q.clksel <= CTRL1_RST[CTRL1_CLK_LSB +: 3];
            q.vref <= CTRL1_RST[CTRL1_REF_LSB +: 2];
            q.trig <= TRIG_RST;
            q.resh <= RES_RST;
            q.resl <= RES_RST;
            q.mask <= IMASK_RST;
        end else begin
            q <= n;
        end
    end

    assign rdata_o = q.rdata;
    assign irq_o = q.irq;
    assign core_power_o = q.pwr;
    assign core_start_o = q.start;
    assign chan_sel_o = q.chan;
    assign vref_sel_o = q.vref;
    assign osc_pins_analog_off_o = q.osc_off;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_sw_go;
        wr_i && addr_i == OFF_CTRL0 && wdata_i[CTRL0_RUN_BIT] && wdata_i[CTRL0_PWR_BIT] && !q.run;
    endsequence

    sequence s_finish;
        cif.done ##1 !q.run;
    endsequence

    sw_start_a: assert property (s_sw_go |=> q.run && core_start_o ##1 cif.busy)
        else $error("software start did not run");
    done_clear_a: assert property (cif.done |-> ##0 s_finish)
        else $error("run flag not cleared at completion");
    power_gate_a: assert property (!core_power_o |-> !q.run && !core_start_o)
        else $error("conversion while powered off");
    right_just_a: assert property ((cif.done && q.just) |=>
        q.resh == {6'h00, $past(core_result_i[9:8])} && q.resl == $past(core_result_i[7:0]))
        else $error("right justified result wrong");
    left_just_a: assert property ((cif.done && !q.just) |=>
        q.resh == $past(core_result_i[9:2]) && q.resl == {$past(core_result_i[1:0]), 6'h00})
        else $error("left justified result wrong");
    trig_start_a: assert property ((trig_hit && n.pwr && !q.run) |=> q.run && core_start_o)
        else $error("trigger edge did not start");
    sleep_block_a: assert property ((sleep_i && !sw_start) |=> !core_start_o)
        else $error("auto start during sleep");
    done_irq_a: assert property (cif.done |=> q.stat && irq_o == q.mask)
        else $error("done flag or interrupt wrong");
    osc_pins_a: assert property (ext_clk_sel_i |=> osc_pins_analog_off_o)
        else $error("oscillator pins still analog");
    no_load_a: assert property (!cif.done && !wr_i |=> $stable(q.resh) && $stable(q.resl))
        else $error("result changed without completion");
endmodule : adcc_top

// >>> tb/tb_adcc_top.sv
/*
 * Self-checking bench of the converter control and result block: register
 * port, software and triggered starts, divider timing, result formats, done
 * interrupt, sleep and power gating.
 * Assumes the design package and the block's sources are compiled first.
 */
`timescale 1ns/10ps
module tb_adcc_top;
    import adcc_pkg::*;
    logic clk_i, reset_i, wr_i, rd_i, sleep_i, ext_clk_sel_i, rc_clk_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o;
    logic [NUM_TRIG:1] trig_src_i;
    logic [RES_W-1:0] core_result_i;
    logic irq_o, core_power_o, core_start_o, osc_pins_analog_off_o;
    logic [5:0] chan_sel_o;
    logic [1:0] vref_sel_o;
    logic mask_v;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int start_cnt = 0;
    int seed;

    adcc_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .trig_src_i(trig_src_i),
        .sleep_i(sleep_i), .ext_clk_sel_i(ext_clk_sel_i), .rc_clk_i(rc_clk_i),
        .core_result_i(core_result_i), .core_power_o(core_power_o),
        .core_start_o(core_start_o), .chan_sel_o(chan_sel_o), .vref_sel_o(vref_sel_o),
        .osc_pins_analog_off_o(osc_pins_analog_off_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // rc clock unrelated to the system clock
    initial begin
        rc_clk_i = 1'b0;
        forever #18.5 rc_clk_i = ~rc_clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (core_start_o === 1'b1) begin
            start_cnt <= start_cnt + 1;
        end
    end

    function automatic int div_of(input logic [2:0] cs);
        int t[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
        return t[cs];
    endfunction : div_of
    function automatic logic [7:0] fmt(input logic js, input logic [9:0] r, input logic hi);
        if (js) begin
            return hi ? {6'h00, r[9:8]} : r[7:0];
        end
        return hi ? r[9:2] : {r[1:0], 6'h00};
    endfunction : fmt

    task automatic complete_run;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cnt(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_cnt
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        chk(d, exp);
    endtask : chk_rd
    // polls the run flag; a hang is cut short here
    task automatic wait_idle(output int n);
        logic [7:0] d;
        int t0;
        t0 = cyc;
        d = 8'h02;
        for (int i = 0; i < 600 && d[CTRL0_RUN_BIT] !== 1'b0; i++) begin
            reg_rd(OFF_CTRL0, d);
        end
        n = cyc - t0;
        if (d[CTRL0_RUN_BIT] !== 1'b0) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, d, 8'h00);
            complete_run();
        end
    endtask : wait_idle

    task automatic run_conv(input logic [2:0] cs, input logic js);
        logic [9:0] r;
        logic [7:0] c1;
        logic [5:0] ch;
        int n, dv, s0;
        r = 10'($random(seed));
        ch = 6'($random(seed));
        c1 = {js, cs, 2'b00, 2'($random(seed))};
        @(posedge clk_i);
        core_result_i <= r;
        reg_wr(OFF_CTRL1, c1);
        chk_rd(OFF_CTRL1, c1);
        chk({6'h00, vref_sel_o}, {6'h00, c1[1:0]});
        s0 = start_cnt;
        reg_wr(OFF_CTRL0, {ch, 2'b11});
        // outputs settle after the launching edge
        #1;
        chk({2'b00, chan_sel_o}, {2'b00, ch});
        chk({7'h00, core_power_o}, 8'h01);
        wait_idle(n);
        dv = div_of(cs);
        if (dv == 0) begin
            chk_cnt(n, 70, 100);
        end else begin
            chk_cnt(n, 11 * dv - 2, 11 * dv + 6);
        end
        chk_cnt(start_cnt - s0, 1, 1);
        chk_rd(OFF_RESH, fmt(js, r, 1'b1));
        chk_rd(OFF_RESL, fmt(js, r, 1'b0));
        chk_rd(OFF_ISTAT, 8'h01);
        chk({7'h00, irq_o}, {7'h00, mask_v});
        reg_wr(OFF_ISTAT, 8'h01);
        chk_rd(OFF_ISTAT, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
    endtask : run_conv

    // long pulse: a level-sensitive start would fire again after done
    task automatic trig_try(input logic [4:0] code, input logic [NUM_TRIG:1] b, input int exp);
        int s0, n;
        reg_wr(OFF_TRIG, {3'h0, code});
        s0 = start_cnt;
        @(posedge clk_i);
        trig_src_i <= b;
        repeat (40) @(posedge clk_i);
        trig_src_i <= '0;
        repeat (8) @(posedge clk_i);
        chk_cnt(start_cnt - s0, exp, exp);
        if (exp > 0) begin
            wait_idle(n);
            reg_wr(OFF_ISTAT, 8'h01);
        end
    endtask : trig_try

    initial begin
        logic [4:0] code;
        int s0;
        seed = 32'hfaa76744;
        {reset_i, wr_i, rd_i, sleep_i, ext_clk_sel_i, mask_v} = 6'b100000;
        addr_i = '0;
        wdata_i = '0;
        trig_src_i = '0;
        core_result_i = '0;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            chk_rd(3'(a), 8'h00);
        end
        reg_wr(3'h7, 8'hff);
        chk_rd(3'h7, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            ext_clk_sel_i <= ~ext_clk_sel_i;
            @(posedge clk_i);
            #1;
            chk({7'h00, osc_pins_analog_off_o}, {7'h00, ext_clk_sel_i});
        end
        reg_wr(OFF_IMASK, 8'h01);
        mask_v = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                reg_wr(OFF_IMASK, 8'h00);
                mask_v = 1'b0;
            end
            run_conv(3'(i), i[0] ^ i[2]);
        end
        reg_wr(OFF_CTRL1, 8'h80);
        for (int k = 1; k <= NUM_TRIG; k++) begin
            trig_try(5'(k), NUM_TRIG'(1) << (k - 1), 1);
        end
        trig_try(TRIG_NONE, '1, 0);
        trig_try(5'h13, '1, 0);
        trig_try(5'h1f, '1, 0);
        code = 5'(2 + ($unsigned($random(seed)) % 17));
        @(posedge clk_i);
        sleep_i <= 1'b1;
        trig_try(code, NUM_TRIG'(1) << (code - 1), 0);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        // abort in mid-conversion leaves no status
        reg_wr(OFF_CTRL0, 8'h03);
        reg_wr(OFF_CTRL0, 8'h01);
        repeat (30) @(posedge clk_i);
        chk_rd(OFF_ISTAT, 8'h00);
        reg_wr(OFF_CTRL0, 8'h00);
        #1;
        chk({7'h00, core_power_o}, 8'h00);
        s0 = start_cnt;
        reg_wr(OFF_CTRL0, 8'h02);
        repeat (4) @(posedge clk_i);
        chk_cnt(start_cnt - s0, 0, 0);
        chk_rd(OFF_CTRL0, 8'h00);
        trig_try(5'h03, NUM_TRIG'(1) << 2, 0);
        complete_run();
    end
endmodule : tb_adcc_top
